// ### logic/capture_compare_timer.sv
// Free-running 16-bit timer with two captures, two compares, Wishbone slave
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Sixteen-bit free-running up-counter, high/low bytes
// - Low-byte write or reset loads FFFCh
// - Prescale CPU clock by two, four, eight
// - High-byte read buffers matching low byte
// - Buffered low byte holds until low read
// - Low read outside sequence returns live byte
// - Wrap FFFFh to 0000h sets wrap flag
// - Wrap interrupt needs enable and clear mask
// - Flag read then count low access clears
// - Shadow low accesses never clear wrap flag
// - Halt freezes count, reset restarts it
// - Tick select three picks external tick pin
// - Edge select picks external active transition
// - Capture edge copies counter into channel
// - Capture sets flag, maskable interrupt request
// - Flag read then capture low access clears
// - Capture high read blocks channel until low
// - Single-pulse or PWM: only second captures
// - Capture pin 1 always feeds capture logic; pin 0 only outside single-pulse or PWM
// - Compare match sets flag, drives pin
// - Compare registers software only, reset 8000h
// - Compare high write inhibits until low write
// - Divide-two matches equal, others plus one
module capture_compare_timer (
	// Clock and reset
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	// Wishbone slave
	input  wire capture_compare_timer_pkg::wb_req_s  wb_req_i,
	output var  capture_compare_timer_pkg::wb_rsp_s  wb_rsp_o,
	// System controls
	input  wire logic                                halt_i,
	input  wire logic                                irq_mask_i,
	// Pins
	input  wire logic [1:0]                          capture_pin_i,
	input  wire logic                                ext_tick_pin_i,
	output logic      [1:0]                          compare_pin_o,
	output logic      [1:0]                          compare_pin_oe_o,
	// Interrupt
	output logic                                     timer_irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic at(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	function automatic logic [7:0] cap_lo_adr(input int i);
		logic [7:0] r;
		if (i == 0) begin
			r = capture_compare_timer_pkg::CAP0_LO_ADR;
		end else begin
			r = capture_compare_timer_pkg::CAP1_LO_ADR;
		end
		return r;
	endfunction

	function automatic logic [7:0] cap_hi_adr(input int i);
		logic [7:0] r;
		if (i == 0) begin
			r = capture_compare_timer_pkg::CAP0_HI_ADR;
		end else begin
			r = capture_compare_timer_pkg::CAP1_HI_ADR;
		end
		return r;
	endfunction

	function automatic logic [7:0] cmp_lo_adr(input int i);
		logic [7:0] r;
		if (i == 0) begin
			r = capture_compare_timer_pkg::CMP0_LO_ADR;
		end else begin
			r = capture_compare_timer_pkg::CMP1_LO_ADR;
		end
		return r;
	endfunction

	function automatic logic [7:0] cmp_hi_adr(input int i);
		logic [7:0] r;
		if (i == 0) begin
			r = capture_compare_timer_pkg::CMP0_HI_ADR;
		end else begin
			r = capture_compare_timer_pkg::CMP1_HI_ADR;
		end
		return r;
	endfunction

	// Channel 0 keeps its edge select in ctrl_one, channel 1 in ctrl_two
	function automatic logic cap_rise_sel(input capture_compare_timer_pkg::state_s s, input int i);
		logic r;
		if (i == 0) begin
			r = s.ctrl_one[capture_compare_timer_pkg::C1_EDGE0];
		end else begin
			r = s.ctrl_two[capture_compare_timer_pkg::C2_EDGE1];
		end
		return r;
	endfunction

	// Level driven onto a compare pin after its match
	function automatic logic cmp_level(input capture_compare_timer_pkg::state_s s, input int i);
		logic r;
		if (i == 0) begin
			r = s.ctrl_one[capture_compare_timer_pkg::C1_LVL0];
		end else begin
			r = s.ctrl_one[capture_compare_timer_pkg::C1_LVL1];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	capture_compare_timer_pkg::state_s s_reg;
	capture_compare_timer_pkg::state_s s_next;

	always_comb begin
		logic       acc;
		logic       rd;
		logic       wr;
		logic [7:0] a;
		logic [7:0] wd;
		logic [7:0] rdat;
		logic [2:0] rise;
		logic [2:0] fall;
		logic       tick;
		logic       ext_edge;
		logic       div2;
		logic       cap_edge;
		logic       cond;
		logic [2:0] last;
		logic [1:0] ts;
		logic       wrap_req;
		logic       cap_req;
		logic       cmp_req;
		acc      = 1'b0;
		rd       = 1'b0;
		wr       = 1'b0;
		a        = 8'h00;
		wd       = 8'h00;
		rdat     = 8'h00;
		rise     = 3'h0;
		fall     = 3'h0;
		tick     = 1'b0;
		ext_edge = 1'b0;
		div2     = 1'b0;
		cap_edge = 1'b0;
		cond     = 1'b0;
		last     = 3'h0;
		ts       = 2'h0;
		wrap_req = 1'b0;
		cap_req  = 1'b0;
		cmp_req  = 1'b0;
		s_next   = s_reg;

		// One access per request; ack drops the cycle after it was given
		acc = wb_req_i.cyc & wb_req_i.stb & ~s_reg.rsp.ack;
		rd  = acc & ~wb_req_i.we;
		wr  = acc & wb_req_i.we & wb_req_i.sel[0];
		a   = wb_req_i.adr;
		wd  = wb_req_i.dat[7:0];
		s_next.rsp.ack = acc;

		// Pins cross two flops; third stage only feeds edge detection
		s_next.sy0 = {ext_tick_pin_i, capture_pin_i};
		s_next.sy1 = s_reg.sy0;
		s_next.prv = s_reg.sy1;
		rise = s_reg.sy1 & ~s_reg.prv;
		fall = ~s_reg.sy1 & s_reg.prv;

		////////////////////////////////////////////////////////////////////
		// Tick generation

		ts   = s_reg.ctrl_two[capture_compare_timer_pkg::C2_TS +: 2];
		div2 = (ts == capture_compare_timer_pkg::TS_DIV2);
		if (ts == capture_compare_timer_pkg::TS_DIV2) begin
			last = capture_compare_timer_pkg::DIV2_LAST;
		end else if (ts == capture_compare_timer_pkg::TS_DIV8) begin
			last = capture_compare_timer_pkg::DIV8_LAST;
		end else begin
			last = capture_compare_timer_pkg::DIV4_LAST;
		end
		// Sampled on the rising edge; an edge pair closer than one clock may merge
		ext_edge = s_reg.ctrl_two[capture_compare_timer_pkg::C2_EXTEDGE] ? rise[2] : fall[2];
		if (!halt_i) begin
			if (ts == capture_compare_timer_pkg::TS_EXT) begin
				tick = ext_edge;
			end else if (s_reg.presc == last) begin
				tick = 1'b1;
				s_next.presc = 3'h0;
			end else begin
				s_next.presc = s_reg.presc + 3'h1;
			end
		end

		////////////////////////////////////////////////////////////////////
		// Register reads

		if (rd) begin
			if (at(a, capture_compare_timer_pkg::CTRL_ONE_ADR)) begin
				rdat = s_reg.ctrl_one;
			end else if (at(a, capture_compare_timer_pkg::CTRL_TWO_ADR)) begin
				rdat = s_reg.ctrl_two;
			end else if (at(a, capture_compare_timer_pkg::FLAG_ADR)) begin
				rdat[capture_compare_timer_pkg::F_CAP0] = s_reg.cap_flag[0];
				rdat[capture_compare_timer_pkg::F_CMP0] = s_reg.cmp_flag[0];
				rdat[capture_compare_timer_pkg::F_WRAP] = s_reg.wrap_flag;
				rdat[capture_compare_timer_pkg::F_CAP1] = s_reg.cap_flag[1];
				rdat[capture_compare_timer_pkg::F_CMP1] = s_reg.cmp_flag[1];
				// First step of every flag clear
				s_next.arm_wrap = s_reg.wrap_flag;
				s_next.arm_cap  = s_reg.cap_flag;
				s_next.arm_cmp  = s_reg.cmp_flag;
			end else if (at(a, capture_compare_timer_pkg::CAP0_HI_ADR)) begin
				rdat = s_reg.cap[0][15:8];
			end else if (at(a, capture_compare_timer_pkg::CAP0_LO_ADR)) begin
				rdat = s_reg.cap[0][7:0];
			end else if (at(a, capture_compare_timer_pkg::CAP1_HI_ADR)) begin
				rdat = s_reg.cap[1][15:8];
			end else if (at(a, capture_compare_timer_pkg::CAP1_LO_ADR)) begin
				rdat = s_reg.cap[1][7:0];
			end else if (at(a, capture_compare_timer_pkg::CMP0_HI_ADR)) begin
				rdat = s_reg.cmp[0][15:8];
			end else if (at(a, capture_compare_timer_pkg::CMP0_LO_ADR)) begin
				rdat = s_reg.cmp[0][7:0];
			end else if (at(a, capture_compare_timer_pkg::CMP1_HI_ADR)) begin
				rdat = s_reg.cmp[1][15:8];
			end else if (at(a, capture_compare_timer_pkg::CMP1_LO_ADR)) begin
				rdat = s_reg.cmp[1][7:0];
			end else if (at(a, capture_compare_timer_pkg::COUNT_HI_ADR)) begin
				rdat = s_reg.cnt[15:8];
				if (!s_reg.cnt_seq) begin
					s_next.cnt_buf = s_reg.cnt[7:0];
				end
				s_next.cnt_seq = 1'b1;
			end else if (at(a, capture_compare_timer_pkg::COUNT_LO_ADR)) begin
				rdat = s_reg.cnt_seq ? s_reg.cnt_buf : s_reg.cnt[7:0];
				s_next.cnt_seq = 1'b0;
			end else if (at(a, capture_compare_timer_pkg::SHADOW_HI_ADR)) begin
				rdat = s_reg.cnt[15:8];
				if (!s_reg.sh_seq) begin
					s_next.sh_buf = s_reg.cnt[7:0];
				end
				s_next.sh_seq = 1'b1;
			end else if (at(a, capture_compare_timer_pkg::SHADOW_LO_ADR)) begin
				rdat = s_reg.sh_seq ? s_reg.sh_buf : s_reg.cnt[7:0];
				s_next.sh_seq = 1'b0;
			end else begin
				rdat = 8'h00;
			end
		end
		s_next.rsp.dat = {24'h000000, rdat};

		////////////////////////////////////////////////////////////////////
		// Register writes

		if (wr) begin
			if (at(a, capture_compare_timer_pkg::CTRL_ONE_ADR)) begin
				s_next.ctrl_one = wd;
			end else if (at(a, capture_compare_timer_pkg::CTRL_TWO_ADR)) begin
				s_next.ctrl_two = wd;
			end
		end

		////////////////////////////////////////////////////////////////////
		// Counter and wrap flag

		// Clear precedes set so a wrap in the clearing cycle survives
		if (acc && at(a, capture_compare_timer_pkg::COUNT_LO_ADR)) begin
			if (s_reg.arm_wrap) begin
				s_next.wrap_flag = 1'b0;
			end
			s_next.arm_wrap = 1'b0;
		end
		if (wr && (at(a, capture_compare_timer_pkg::COUNT_LO_ADR) ||
		    at(a, capture_compare_timer_pkg::SHADOW_LO_ADR))) begin
			s_next.cnt   = capture_compare_timer_pkg::COUNT_RELOAD;
			s_next.presc = 3'h0;
		end else if (tick) begin
			s_next.cnt = s_reg.cnt + 16'h0001;
			if (s_reg.cnt == capture_compare_timer_pkg::COUNT_MAX) begin
				s_next.wrap_flag = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////////
		// Capture and compare channels

		for (int i = 0; i < 2; i++) begin
			// Capture low access completes the clear; a capture low read reopens the channel
			if (acc && at(a, cap_lo_adr(i))) begin
				if (s_reg.arm_cap[i]) begin
					s_next.cap_flag[i] = 1'b0;
				end
				s_next.arm_cap[i] = 1'b0;
				if (rd) begin
					s_next.cap_block[i] = 1'b0;
				end
			end
			if (rd && at(a, cap_hi_adr(i))) begin
				s_next.cap_block[i] = 1'b1;
			end
			cap_edge = cap_rise_sel(s_reg, i) ? rise[i] : fall[i];
			if (i == 0 && (s_reg.ctrl_two[capture_compare_timer_pkg::C2_OPM] ||
			    s_reg.ctrl_two[capture_compare_timer_pkg::C2_PWM])) begin
				cap_edge = 1'b0;
			end
			if (cap_edge && !s_reg.cap_block[i] && !(rd && at(a, cap_hi_adr(i)))) begin
				s_next.cap[i]      = s_reg.cnt;
				s_next.cap_flag[i] = 1'b1;
			end

			// Compare value: software only, high write inhibits
			if (acc && at(a, cmp_lo_adr(i))) begin
				if (s_reg.arm_cmp[i]) begin
					s_next.cmp_flag[i] = 1'b0;
				end
				s_next.arm_cmp[i] = 1'b0;
			end
			if (wr && at(a, cmp_hi_adr(i))) begin
				s_next.cmp[i][15:8]  = wd;
				s_next.cmp_block[i] = 1'b1;
			end
			if (wr && at(a, cmp_lo_adr(i))) begin
				s_next.cmp[i][7:0]  = wd;
				s_next.cmp_block[i] = 1'b0;
			end
			// Slower ticks resolve one count late, hence the plus one
			cond = div2 ? (s_reg.cnt == s_reg.cmp[i]) :
			       (s_reg.cnt == s_reg.cmp[i] + 16'h0001);
			cond = cond & ~s_reg.cmp_block[i];
			s_next.match_prv[i] = cond;
			if (cond && !s_reg.match_prv[i]) begin
				s_next.cmp_flag[i] = 1'b1;
				if (s_reg.oe[i]) begin
					s_next.pin[i] = cmp_level(s_reg, i);
				end
			end
		end
		s_next.oe[0] = s_reg.ctrl_two[capture_compare_timer_pkg::C2_DRV0];
		s_next.oe[1] = s_reg.ctrl_two[capture_compare_timer_pkg::C2_DRV1];

		////////////////////////////////////////////////////////////////////
		// Interrupt: pending flags wait for enable and open mask

		// Flags stay set while masked, so a request fires once the mask opens
		wrap_req   = s_reg.wrap_flag & s_reg.ctrl_one[capture_compare_timer_pkg::C1_WRAP_IE];
		cap_req    = (|s_reg.cap_flag) & s_reg.ctrl_one[capture_compare_timer_pkg::C1_CAP_IE];
		cmp_req    = (|s_reg.cmp_flag) & s_reg.ctrl_one[capture_compare_timer_pkg::C1_CMP_IE];
		s_next.irq = ~irq_mask_i & (wrap_req | cap_req | cmp_req);

		if (rst_i) begin
			s_next        = '0;
			s_next.cnt    = capture_compare_timer_pkg::COUNT_RELOAD;
			s_next.cmp[0] = capture_compare_timer_pkg::CMP_RESET;
			s_next.cmp[1] = capture_compare_timer_pkg::CMP_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_rsp_o         = s_reg.rsp;
	assign compare_pin_o    = s_reg.pin;
	assign compare_pin_oe_o = s_reg.oe;
	assign timer_irq_o      = s_reg.irq;

endmodule

`default_nettype wire

// ### logic/capture_compare_timer_pkg.sv
// Constants, register map and carrier types of the capture/compare timer
package capture_compare_timer_pkg;

	// Register byte addresses, one aligned word each, data in bits 7:0
	localparam logic [7:0] CTRL_ONE_ADR   = 8'h00;
	localparam logic [7:0] CTRL_TWO_ADR   = 8'h04;
	localparam logic [7:0] FLAG_ADR       = 8'h08;
	localparam logic [7:0] CAP0_HI_ADR    = 8'h0C;
	localparam logic [7:0] CAP0_LO_ADR    = 8'h10;
	localparam logic [7:0] CAP1_HI_ADR    = 8'h14;
	localparam logic [7:0] CAP1_LO_ADR    = 8'h18;
	localparam logic [7:0] CMP0_HI_ADR    = 8'h1C;
	localparam logic [7:0] CMP0_LO_ADR    = 8'h20;
	localparam logic [7:0] CMP1_HI_ADR    = 8'h24;
	localparam logic [7:0] CMP1_LO_ADR    = 8'h28;
	localparam logic [7:0] COUNT_HI_ADR   = 8'h2C;
	localparam logic [7:0] COUNT_LO_ADR   = 8'h30;
	localparam logic [7:0] SHADOW_HI_ADR  = 8'h34;
	localparam logic [7:0] SHADOW_LO_ADR  = 8'h38;

	// ctrl_one fields
	localparam int C1_CAP_IE  = 7;
	localparam int C1_CMP_IE  = 6;
	localparam int C1_WRAP_IE = 5;
	localparam int C1_LVL1    = 3;
	localparam int C1_EDGE0   = 1;
	localparam int C1_LVL0    = 0;
	// ctrl_two fields
	localparam int C2_DRV1    = 7;
	localparam int C2_DRV0    = 6;
	localparam int C2_PWM     = 5;
	localparam int C2_OPM     = 4;
	localparam int C2_TS      = 2;
	localparam int C2_EDGE1   = 1;
	localparam int C2_EXTEDGE = 0;
	// flag_register fields
	localparam int F_CAP0 = 7;
	localparam int F_CMP0 = 6;
	localparam int F_WRAP = 5;
	localparam int F_CAP1 = 4;
	localparam int F_CMP1 = 3;

	// tick_select encodings
	localparam logic [1:0] TS_DIV4 = 2'h0;
	localparam logic [1:0] TS_DIV2 = 2'h1;
	localparam logic [1:0] TS_DIV8 = 2'h2;
	localparam logic [1:0] TS_EXT  = 2'h3;
	localparam logic [2:0] DIV2_LAST = 3'h1;
	localparam logic [2:0] DIV4_LAST = 3'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	// Reset and reload values
	localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
	localparam logic [15:0] CMP_RESET    = 16'h8000;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic [15:0]      cnt;
		logic [2:0]       presc;
		logic [2:0]       sy0;
		logic [2:0]       sy1;
		logic [2:0]       prv;
		logic [7:0]       ctrl_one;
		logic [7:0]       ctrl_two;
		logic [1:0][15:0] cap;
		logic [1:0][15:0] cmp;
		logic             wrap_flag;
		logic [1:0]       cap_flag;
		logic [1:0]       cmp_flag;
		logic             arm_wrap;
		logic [1:0]       arm_cap;
		logic [1:0]       arm_cmp;
		logic [1:0]       cap_block;
		logic [1:0]       cmp_block;
		logic [7:0]       cnt_buf;
		logic             cnt_seq;
		logic [7:0]       sh_buf;
		logic             sh_seq;
		logic [1:0]       match_prv;
		logic [1:0]       pin;
		logic [1:0]       oe;
		logic             irq;
		wb_rsp_s          rsp;
	} state_s;

endpackage

// ### verification/capture_compare_timer_checker.sv
// Port-level assertions of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_checker (
	// Clock and reset
	input wire logic                               clk_i,
	input wire logic                               rst_i,
	// Bus
	input wire capture_compare_timer_pkg::wb_req_s wb_req_i,
	input wire capture_compare_timer_pkg::wb_rsp_s wb_rsp_o,
	// Controls and pins
	input wire logic                               irq_mask_i,
	input wire logic [1:0]                         compare_pin_o,
	input wire logic [1:0]                         compare_pin_oe_o,
	input wire logic                               timer_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
	chk_ack_take: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("request not answered");
	chk_ack_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
		else $error("read data outside ack");
	// Reset itself is the cause here, so no disable
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !timer_irq_o && compare_pin_o == 2'h0
		&& compare_pin_oe_o == 2'h0) else $error("outputs active after reset");
	chk_oe_follow: assert property (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !wb_rsp_o.ack
		&& wb_req_i.adr == capture_compare_timer_pkg::CTRL_TWO_ADR && wb_req_i.sel[0]
		|-> ##2 compare_pin_oe_o == $past(wb_req_i.dat[7:6], 2)) else $error("enable not following");
	chk_pin_gated: assert property (((compare_pin_o ^ $past(compare_pin_o)) & ~$past(compare_pin_oe_o)) == 2'h0)
		else $error("pin moved while not driven");
	chk_irq_masked: assert property (irq_mask_i |=> !timer_irq_o)
		else $error("interrupt while masked");
endmodule
bind capture_compare_timer capture_compare_timer_checker i_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .irq_mask_i(irq_mask_i),
	.compare_pin_o(compare_pin_o), .compare_pin_oe_o(compare_pin_oe_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// ### verification/capture_compare_timer_tb.sv
// Self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module capture_compare_timer_tb;
	logic                               clk_i, rst_i, halt, mask, run, ext_pin, irq;
	logic [1:0]                         cap, cap_pin, cmp_pin, cmp_oe;
	capture_compare_timer_pkg::wb_req_s wb_req;
	capture_compare_timer_pkg::wb_rsp_s wb_rsp;
	int                                 bad_count, check_count;
	capture_compare_timer i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
		.halt_i(halt), .irq_mask_i(mask), .capture_pin_i(cap_pin), .ext_tick_pin_i(ext_pin),
		.compare_pin_o(cmp_pin), .compare_pin_oe_o(cmp_oe), .timer_irq_o(irq));
	timer_pins_model i_pins (.clk_i(clk_i), .run_i(run), .cap_i(cap), .capture_pin_o(cap_pin),
		.ext_tick_pin_o(ext_pin));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Master waits for ack, never a fixed count
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		wb_req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		// Only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk_i);
		end while (wb_rsp.ack !== 1'b1);
		q = wb_rsp.dat[7:0];
		if (w) begin
			chk(q, 8'h00);
		end
		wb_req <= '0;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h0, q);
		chk(q, e);
	endtask
	task rf(input logic [7:0] e, input logic [7:0] m);
		logic [7:0] q;
		bus(1'b0, capture_compare_timer_pkg::FLAG_ADR, 8'h0, q);
		chk(q & m, e);
	endtask
	task cl;
		wr(capture_compare_timer_pkg::COUNT_LO_ADR, 8'h00);
	endtask
	task run_cnt(input int n);
		@(posedge clk_i);
		halt <= 1'b0;
		repeat (n) @(posedge clk_i);
		halt <= 1'b1;
	endtask
	task cap_edge(input logic [1:0] v);
		@(posedge clk_i);
		cap <= v;
		repeat (6) @(posedge clk_i);
	endtask
	////////////////////////////////////////
	task t_regs;
		rd(capture_compare_timer_pkg::CMP0_HI_ADR, 8'h80);
		rd(capture_compare_timer_pkg::CMP0_LO_ADR, 8'h00);
		wr(capture_compare_timer_pkg::CMP1_HI_ADR, 8'h12);
		wr(capture_compare_timer_pkg::CMP1_LO_ADR, 8'h34);
		rd(capture_compare_timer_pkg::CMP1_HI_ADR, 8'h12);
		rd(capture_compare_timer_pkg::CMP1_LO_ADR, 8'h34);
		wr(capture_compare_timer_pkg::CAP0_HI_ADR, 8'h55);
		rd(capture_compare_timer_pkg::CAP0_HI_ADR, 8'h00);
		rd(capture_compare_timer_pkg::CAP0_LO_ADR, 8'h00);
		rd(8'h3C, 8'h00);
		$display("test regs done");
	endtask
	task t_seq;
		cl();
		rd(capture_compare_timer_pkg::COUNT_HI_ADR, 8'hFF);
		run_cnt(8);
		rd(capture_compare_timer_pkg::COUNT_HI_ADR, 8'hFF);
		rd(capture_compare_timer_pkg::COUNT_LO_ADR, 8'hFC);
		rd(capture_compare_timer_pkg::COUNT_LO_ADR, 8'hFE);
		rd(capture_compare_timer_pkg::SHADOW_HI_ADR, 8'hFF);
		rd(capture_compare_timer_pkg::SHADOW_LO_ADR, 8'hFE);
		$display("test sequence done");
	endtask
	task t_div;
		logic [1:0] ts[3];
		logic [7:0] n, w;
		ts = '{capture_compare_timer_pkg::TS_DIV2, capture_compare_timer_pkg::TS_DIV4,
			capture_compare_timer_pkg::TS_DIV8};
		wr(capture_compare_timer_pkg::CTRL_ONE_ADR, 8'h20);
		for (int i = 0; i < 3; i++) begin
			n = 8'h10 >> (i + 1);
			w = (n >= 8'h4) ? 8'h20 : 8'h00;
			wr(capture_compare_timer_pkg::CTRL_TWO_ADR, {4'h0, ts[i], 2'h0});
			cl();
			run_cnt(16);
			rf(w, 8'h20);
			rd(capture_compare_timer_pkg::SHADOW_LO_ADR, 8'hFC + n);
			rf(w, 8'h20);
			chk({7'h0, irq}, 8'h00);
			@(posedge clk_i);
			mask <= 1'b0;
			repeat (2) @(posedge clk_i);
			chk({7'h0, irq}, w >> 5);
			rd(capture_compare_timer_pkg::COUNT_LO_ADR, 8'hFC + n);
			rf(8'h00, 8'h20);
			repeat (2) @(posedge clk_i);
			chk({7'h0, irq}, 8'h00);
			mask <= 1'b1;
		end
		$display("test prescaler done");
	endtask
	task t_ext;
		for (int s = 0; s < 2; s++) begin
			wr(capture_compare_timer_pkg::CTRL_TWO_ADR, {4'h0, capture_compare_timer_pkg::TS_EXT, 1'b0, s[0]});
			cl();
			@(posedge clk_i);
			halt <= 1'b0;
			run <= 1'b1;
			repeat (28) @(posedge clk_i);
			run <= 1'b0;
			repeat (8) @(posedge clk_i);
			halt <= 1'b1;
			rd(capture_compare_timer_pkg::COUNT_LO_ADR, 8'hFF);
		end
		$display("test external tick done");
	endtask
	task t_cap;
		wr(capture_compare_timer_pkg::CTRL_ONE_ADR, 8'h22);
		wr(capture_compare_timer_pkg::CTRL_TWO_ADR, 8'h00);
		cl();
		cap_edge(2'h1);
		rf(8'h80, 8'h80);
		rd(capture_compare_timer_pkg::CAP0_HI_ADR, 8'hFF);
		cap_edge(2'h0);
		run_cnt(8);
		cap_edge(2'h1);
		rd(capture_compare_timer_pkg::CAP0_LO_ADR, 8'hFC);
		rf(8'h00, 8'h80);
		cap_edge(2'h0);
		cap_edge(2'h1);
		rf(8'h80, 8'h80);
		rd(capture_compare_timer_pkg::CAP0_LO_ADR, 8'hFE);
		wr(capture_compare_timer_pkg::CTRL_TWO_ADR, 8'h10);
		cap_edge(2'h0);
		cap_edge(2'h1);
		rf(8'h00, 8'h80);
		cap_edge(2'h3);
		cap_edge(2'h1);
		rf(8'h10, 8'h10);
		wr(capture_compare_timer_pkg::CAP1_LO_ADR, 8'h00);
		rf(8'h00, 8'h10);
		$display("test capture done");
	endtask
	task t_cmp;
		wr(capture_compare_timer_pkg::CTRL_ONE_ADR, 8'h21);
		wr(capture_compare_timer_pkg::CMP0_LO_ADR, 8'hFE);
		wr(capture_compare_timer_pkg::CMP0_HI_ADR, 8'hFF);
		wr(capture_compare_timer_pkg::CTRL_TWO_ADR, 8'h44);
		cl();
		run_cnt(8);
		rf(8'h00, 8'h40);
		chk({7'h0, cmp_pin[0]}, 8'h00);
		wr(capture_compare_timer_pkg::CMP0_LO_ADR, 8'hFE);
		cl();
		run_cnt(4);
		rf(8'h40, 8'h40);
		chk({7'h0, cmp_pin[0]}, 8'h01);
		rd(capture_compare_timer_pkg::CMP0_LO_ADR, 8'hFE);
		rf(8'h00, 8'h40);
		wr(capture_compare_timer_pkg::CTRL_TWO_ADR, 8'h40);
		wr(capture_compare_timer_pkg::CTRL_ONE_ADR, 8'h20);
		cl();
		run_cnt(8);
		rf(8'h00, 8'h40);
		run_cnt(4);
		rf(8'h40, 8'h40);
		chk({7'h0, cmp_pin[0]}, 8'h00);
		$display("test compare done");
	endtask
	////////////////////////////////////////
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Whole run is well under a thousand cycles; this leaves wide margin
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		print_verdict();
	end
	initial begin
		rst_i = 1'b1;
		halt = 1'b1;
		mask = 1'b1;
		run = 1'b0;
		cap = 2'h0;
		wb_req = '0;
		bad_count = 0;
		check_count = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_seq();
		t_div();
		t_ext();
		t_cap();
		t_cmp();
		print_verdict();
	end
endmodule
`default_nettype wire

// ### verification/timer_pins_model.sv
// Far-side pin model: capture pins and external tick source
`timescale 1ns/1ns
`default_nettype none
module timer_pins_model (
	// Clock and commands
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic [1:0] cap_i,
	// Pins
	output logic      [1:0] capture_pin_o,
	output logic            ext_tick_pin_o
);
	logic [1:0] div_reg;
	initial begin
		div_reg = 2'h0;
		capture_pin_o = 2'h0;
		ext_tick_pin_o = 1'b0;
	end
	////////////////////////////////////////
	// Edge every four clocks, active edges eight apart; stands still when idle
	always @(posedge clk_i) begin
		capture_pin_o <= cap_i;
		if (run_i) begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'h3) begin
				ext_tick_pin_o <= ~ext_tick_pin_o;
			end
		end
	end
endmodule
`default_nettype wire
